// *** core/card_load_pkg.sv ***
// constants and types for the card load control sequencer
//
// Contract
// (RULE_01) 400 locations form 40 ten-word card blocks
// (RULE_02) block: sector one last nine, sector two first
// (RULE_03) card word fields enter matching buffer positions
// (RULE_04) load card: next fetch from operand address
// (RULE_05) read start gives three run-in cycles only
// (RULE_06) third run-in: buffer filled, relay set if load
// (RULE_07) computer reset clears program, distributor, accumulator
// (RULE_08) run reset: address 8000, commutator starts fetch
// (RULE_09) fetch at 8000 copies entry switches to program
// (RULE_10) restart word loads opcode and operand address
// (RULE_11) read opcode feeds reader, copies buffer to band
// (RULE_12) buffer erased to blank right after copy
// (RULE_13) reader sends back signal at 300 degrees
// (RULE_14) relay set diverts back signal to take-operand
// (RULE_15) take-operand flips alternation latch toward fetch
// (RULE_16) diverted: no restart, registers keep contents
// (RULE_17) normal restart loads next-instruction address, fetches
// (RULE_18) non-load cards lack the load punch
// (RULE_19) relay re-evaluated each reader cycle from card
// (RULE_20) blank code differs from every valid digit
package card_load_pkg;

  localparam int WORD_W          = 40;
  localparam int ADDR_W          = 16;
  localparam int OP_W            = 8;
  localparam int BLOCKS          = 40;
  localparam int BLOCK_WORDS     = 10;
  localparam int STORE_WORDS     = 400;
  localparam int BAND_WORDS      = 50;
  localparam int BLOCK_FIRST_POS = 1;
  localparam int RUNIN_CYCLES    = 3;
  localparam int OP_MSB          = 39;
  localparam int OP_LSB          = 32;
  localparam int D_MSB           = 31;
  localparam int D_LSB           = 16;
  localparam int I_MSB           = 15;
  localparam int I_LSB           = 0;

  localparam logic [ADDR_W-1:0] ADDR_SWITCHES = 16'h8000;
  localparam logic [OP_W-1:0]   OP_READ       = 8'h70;
  localparam logic [OP_W-1:0]   OP_NONE       = 8'h00;
  localparam logic [WORD_W-1:0] WORD_ZERO     = 40'h00_0000_0000;
  localparam logic [WORD_W-1:0] BLANK_WORD    = 40'hFF_FFFF_FFFF;

  typedef logic [WORD_W-1:0] word_t;
  typedef logic [ADDR_W-1:0] addr_t;

  typedef struct packed {
    logic       strobe;
    logic       load_punch;
    logic       back_cam;
    logic [3:0] index;
    word_t      word;
  } reader_in_t;

  typedef struct packed {
    logic  program_start;
    logic  read_start;
    logic  computer_reset;
    logic  run_switch;
    word_t entry;
  } panel_in_t;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_FETCH,
    ST_RESTART_D,
    ST_TRANSFER,
    ST_WAIT_BACK,
    ST_RESTART_I
  } commutator_state_t;

endpackage

// *** core/card_load_control_sequencer.sv ***
// card load control sequencer: commutator, read buffer, card blocks
`timescale 1ns/1ps
`default_nettype none

module card_load_control_sequencer #(
  parameter int BLOCKS      = card_load_pkg::BLOCKS,
  parameter int BLOCK_WORDS = card_load_pkg::BLOCK_WORDS
) (
  input  wire logic                         clock,
  input  wire logic                         reset_n,
  input  wire card_load_pkg::reader_in_t    reader_in,
  input  wire card_load_pkg::panel_in_t     panel_in,
  input  wire card_load_pkg::word_t         drum_word,
  input  wire logic                         drum_word_valid,
  input  wire logic [8:0]                   store_address,
  output logic                              reader_feed,
  output logic                              fetch_request,
  output card_load_pkg::addr_t              fetch_address,
  output card_load_pkg::word_t              program_register,
  output logic [card_load_pkg::OP_W-1:0]    op_register,
  output card_load_pkg::addr_t              address_register,
  output card_load_pkg::word_t              distributor,
  output logic [2*card_load_pkg::WORD_W-1:0] accumulator,
  output logic                              fetch_half,
  output logic                              back_relay,
  output logic                              runin_done,
  output card_load_pkg::word_t              store_data
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  card_load_pkg::word_t              card_store [BLOCKS*BLOCK_WORDS];
  card_load_pkg::word_t              read_buffer_store [BLOCK_WORDS];
  card_load_pkg::reader_in_t         reader_s1;
  card_load_pkg::reader_in_t         reader_s2;
  card_load_pkg::reader_in_t         reader_prev;
  card_load_pkg::panel_in_t          panel_s1;
  card_load_pkg::panel_in_t          panel_s2;
  card_load_pkg::panel_in_t          panel_prev;
  card_load_pkg::commutator_state_t  state;
  logic [3:0]                        xfer_count;
  logic [1:0]                        runin_count;
  logic                              runin_active;
  logic                              pending_load;

  // ----------------------------------------------------------------
  // address conversion
  // ----------------------------------------------------------------
  function automatic logic [13:0] bcd_to_bin(input card_load_pkg::addr_t a);
    int value;
    value = 1000 * int'(a[15:12]) + 100 * int'(a[11:8]) + 10 * int'(a[7:4]) + int'(a[3:0]);
    return 14'(value);
  endfunction

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reader_s1   <= '0;
      reader_s2   <= '0;
      reader_prev <= '0;
      panel_s1    <= '0;
      panel_s2    <= '0;
      panel_prev  <= '0;
    end
    else
    begin
      reader_s1   <= reader_in;
      reader_s2   <= reader_s1;
      reader_prev <= reader_s2;
      panel_s1    <= panel_in;
      panel_s2    <= panel_s1;
      panel_prev  <= panel_s2;
    end
  end

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire        strobe_edge  = reader_s2.strobe & ~reader_prev.strobe;
  wire        cam_edge     = reader_s2.back_cam & ~reader_prev.back_cam;
  wire        start_edge   = panel_s2.program_start & ~panel_prev.program_start;
  wire        read_key     = panel_s2.read_start & ~panel_prev.read_start;
  wire        creset_pulse = panel_s2.computer_reset & ~panel_prev.computer_reset;
  wire [7:0]  prog_op      = program_register[card_load_pkg::OP_MSB:card_load_pkg::OP_LSB];
  wire [15:0] prog_d       = program_register[card_load_pkg::D_MSB:card_load_pkg::D_LSB];
  wire [15:0] prog_i       = program_register[card_load_pkg::I_MSB:card_load_pkg::I_LSB];
  wire [13:0] addr_bin     = bcd_to_bin(address_register);
  wire [8:0]  addr_band    = 9'(addr_bin / 14'(card_load_pkg::BAND_WORDS));
  wire [5:0]  addr_pos     = 6'(addr_bin % 14'(card_load_pkg::BAND_WORDS));
  // only general storage bands own a card block
  wire        band_ok      = (addr_band < 9'(BLOCKS)); // RULE_01
  // block = last nine of sector one plus first of sector two
  wire        in_block     = band_ok // RULE_02
                           && (addr_pos >= 6'(card_load_pkg::BLOCK_FIRST_POS))
                           && (addr_pos < 6'(card_load_pkg::BLOCK_FIRST_POS + BLOCK_WORDS));
  wire [8:0]  band_base    = addr_band * 9'(BLOCK_WORDS); // RULE_01
  wire [8:0]  block_index  = band_base + 9'(addr_pos - 6'(card_load_pkg::BLOCK_FIRST_POS));
  wire [8:0]  write_index  = band_base + 9'(xfer_count);
  wire        is_switches  = (address_register == card_load_pkg::ADDR_SWITCHES);
  wire        fetch_ready  = is_switches | in_block | drum_word_valid;
  wire        last_xfer    = (xfer_count == 4'(BLOCK_WORDS - 1));
  wire        read_op      = (state == card_load_pkg::ST_RESTART_D)
                           && (prog_op == card_load_pkg::OP_READ);
  wire        divert       = cam_edge & back_relay; // RULE_14
  wire        runin_start  = read_key & ~runin_active & (runin_count == 2'd0); // RULE_05
  wire [1:0]  runin_inc    = runin_count + 2'd1;
  wire        runin_more   = runin_active & cam_edge & (runin_inc < 2'(card_load_pkg::RUNIN_CYCLES));
  wire        next_feed    = runin_start | runin_more | read_op; // RULE_11

  card_load_pkg::word_t fetch_word;
  assign fetch_word    = is_switches ? panel_s2.entry // RULE_09
                       : in_block    ? card_store[block_index]
                       : drum_word;
  assign fetch_request = (state == card_load_pkg::ST_FETCH) & ~is_switches & ~in_block;
  assign fetch_address = address_register;
  assign runin_done    = (runin_count == 2'(card_load_pkg::RUNIN_CYCLES));

  // ----------------------------------------------------------------
  // control commutator
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state            <= card_load_pkg::ST_IDLE;
      fetch_half       <= 1'b1;
      op_register      <= card_load_pkg::OP_NONE;
      address_register <= '0;
      program_register <= card_load_pkg::WORD_ZERO;
      distributor      <= card_load_pkg::WORD_ZERO;
      accumulator      <= '0;
      xfer_count       <= '0;
    end
    else if (creset_pulse)
    begin
      program_register <= card_load_pkg::WORD_ZERO; // RULE_07
      distributor      <= card_load_pkg::WORD_ZERO; // RULE_07
      accumulator      <= '0; // RULE_07
      state            <= card_load_pkg::ST_IDLE;
      xfer_count       <= '0;
      if (panel_s2.run_switch)
      begin
        address_register <= card_load_pkg::ADDR_SWITCHES; // RULE_08
        fetch_half       <= 1'b1; // RULE_08
      end
    end
    else
    begin
      unique case (state)
        card_load_pkg::ST_IDLE:
        begin
          if (start_edge)
            state <= card_load_pkg::ST_FETCH;
        end
        card_load_pkg::ST_FETCH:
        begin
          if (fetch_ready)
          begin
            program_register <= fetch_word; // RULE_09
            fetch_half       <= 1'b0; // RULE_10
            state            <= card_load_pkg::ST_RESTART_D;
          end
        end
        card_load_pkg::ST_RESTART_D:
        begin
          op_register      <= prog_op; // RULE_10
          address_register <= prog_d; // RULE_10
          state            <= (prog_op == card_load_pkg::OP_READ) ? card_load_pkg::ST_TRANSFER
                                                                  : card_load_pkg::ST_RESTART_I;
        end
        card_load_pkg::ST_TRANSFER:
        begin
          xfer_count <= last_xfer ? 4'd0 : xfer_count + 4'd1; // RULE_12
          if (last_xfer)
            state <= card_load_pkg::ST_WAIT_BACK;
        end
        card_load_pkg::ST_WAIT_BACK:
        begin
          if (divert)
          begin
            fetch_half <= ~fetch_half; // RULE_15
            state      <= card_load_pkg::ST_FETCH; // RULE_04 RULE_16
          end
          else if (cam_edge)
            state <= card_load_pkg::ST_RESTART_I;
        end
        card_load_pkg::ST_RESTART_I:
        begin
          op_register      <= card_load_pkg::OP_NONE; // RULE_17
          address_register <= prog_i; // RULE_17
          fetch_half       <= 1'b1;
          state            <= card_load_pkg::ST_FETCH;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read buffer: card entry, erase after transfer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int k = 0; k < BLOCK_WORDS; k++)
        read_buffer_store[k] <= card_load_pkg::BLANK_WORD;
    end
    else
    begin
      if (state == card_load_pkg::ST_TRANSFER)
        read_buffer_store[xfer_count] <= card_load_pkg::BLANK_WORD; // RULE_12 RULE_20
      if (strobe_edge && (reader_s2.index < 4'(BLOCK_WORDS)))
        read_buffer_store[reader_s2.index] <= reader_s2.word; // RULE_03
    end
  end

  // ----------------------------------------------------------------
  // card blocks
  // ----------------------------------------------------------------
  always_ff @(posedge clock)
  begin
    if (state == card_load_pkg::ST_TRANSFER && band_ok)
      card_store[write_index] <= read_buffer_store[xfer_count]; // RULE_11 RULE_01
    store_data <= card_store[store_address];
  end

  // ----------------------------------------------------------------
  // reader control: run-in, feed, back-signal relay
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge reset_n)
  begin
    if (!reset_n)
    begin
      reader_feed  <= 1'b0;
      runin_count  <= '0;
      runin_active <= 1'b0;
      back_relay   <= 1'b0;
      pending_load <= 1'b0;
    end
    else
    begin
      reader_feed <= next_feed;
      if (runin_start)
        runin_active <= 1'b1; // RULE_05
      else if (runin_active && cam_edge)
      begin
        runin_count  <= runin_inc;
        runin_active <= runin_more;
      end
      if (cam_edge)
      begin
        back_relay   <= pending_load | (strobe_edge & reader_s2.load_punch); // RULE_19 RULE_06
        pending_load <= 1'b0;
      end
      else if (strobe_edge && reader_s2.load_punch)
        pending_load <= 1'b1; // RULE_18
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!reset_n);

  a_reset_clears: assert property (creset_pulse |=> // RULE_07
      program_register == card_load_pkg::WORD_ZERO && distributor == card_load_pkg::WORD_ZERO
      && accumulator == '0)
    else $error("computer reset left a register nonzero");

  a_reset_run_addr: assert property (creset_pulse && panel_s2.run_switch |=> // RULE_08
      address_register == card_load_pkg::ADDR_SWITCHES && fetch_half
      && state == card_load_pkg::ST_IDLE)
    else $error("run reset did not set 8000 and fetch half");

  a_switch_fetch: assert property (!creset_pulse && state == card_load_pkg::ST_FETCH // RULE_09
      && is_switches |=> program_register == $past(panel_s2.entry)
      && state == card_load_pkg::ST_RESTART_D)
    else $error("entry switches not copied on fetch at 8000");

  a_restart_regs: assert property (!creset_pulse && state == card_load_pkg::ST_RESTART_D |=> // RULE_10
      op_register == $past(prog_op) && address_register == $past(prog_d) && !fetch_half)
    else $error("restart word did not load op and address");

  a_read_feed: assert property (!creset_pulse && read_op |=> // RULE_11
      reader_feed && state == card_load_pkg::ST_TRANSFER ##1 !reader_feed)
    else $error("read opcode did not give one feed pulse");

  a_transfer_span: assert property ($rose(state == card_load_pkg::ST_TRANSFER) // RULE_12
      && !creset_pulse |-> (state == card_load_pkg::ST_TRANSFER) [*8]
      ##1 (state == card_load_pkg::ST_TRANSFER) [*2] ##1 state == card_load_pkg::ST_WAIT_BACK)
    else $error("transfer did not take ten words");

  a_erase_blank: assert property (!creset_pulse && state == card_load_pkg::ST_TRANSFER // RULE_20
      && !(strobe_edge && reader_s2.index == xfer_count)
      |=> read_buffer_store[$past(xfer_count)] == card_load_pkg::BLANK_WORD)
    else $error("buffer position not erased to blank");

  a_divert_keeps: assert property (!creset_pulse && state == card_load_pkg::ST_WAIT_BACK // RULE_16
      && divert |=> state == card_load_pkg::ST_FETCH && $stable(op_register)
      && $stable(address_register) && fetch_half != $past(fetch_half))
    else $error("diverted back signal disturbed registers");

  a_normal_restart: assert property (!creset_pulse && state == card_load_pkg::ST_WAIT_BACK // RULE_17
      && cam_edge && !back_relay ##1 !creset_pulse |=> state == card_load_pkg::ST_FETCH
      && op_register == card_load_pkg::OP_NONE && address_register == $past(prog_i, 2))
    else $error("normal restart did not take next-instruction address");

  a_relay_update: assert property (cam_edge |=> back_relay == // RULE_19
      ($past(pending_load) | ($past(strobe_edge) & $past(reader_s2.load_punch))))
    else $error("back relay not re-evaluated at cam");

  a_runin_limit: assert property (runin_done && read_key |=> !reader_feed || $past(read_op)) // RULE_05
    else $error("read start key effective after run-in");

  a_buffer_entry: assert property (strobe_edge && reader_s2.index < 4'(BLOCK_WORDS) |=> // RULE_03
      read_buffer_store[$past(reader_s2.index)] == $past(reader_s2.word))
    else $error("card word field not entered in buffer");

  a_runin_end: assert property (runin_active && cam_edge // RULE_05
      && runin_inc == 2'(card_load_pkg::RUNIN_CYCLES) |=> runin_done && !runin_active
      && (!reader_feed || $past(read_op)))
    else $error("run-in did not stop after three cycles");

  a_transfer_copy: assert property (state == card_load_pkg::ST_TRANSFER && band_ok |=> // RULE_11
      card_store[$past(write_index)] == $past(read_buffer_store[xfer_count]))
    else $error("buffer word not copied to card block");

  a_wait_hold: assert property (!creset_pulse && state == card_load_pkg::ST_WAIT_BACK // RULE_14
      && !cam_edge |=> state == card_load_pkg::ST_WAIT_BACK)
    else $error("commutator left wait without back signal");

  a_drum_wait: assert property (!creset_pulse && fetch_request && !drum_word_valid // RULE_17
      |=> state == card_load_pkg::ST_FETCH && $stable(program_register))
    else $error("fetch went on without drum word");

endmodule

`default_nettype wire

// *** testbench/card_reader_model.sv ***
// card reader model: run-in and card cycles with cam back signal
`timescale 1ns/1ps
`default_nettype none

module card_reader_model #(
  parameter int FEED_GAP = 20,
  parameter int RUNIN    = 3
) (
  input  wire logic                 clock,
  input  wire logic                 reset_n,
  input  wire logic                 reader_feed,
  input  wire card_load_pkg::word_t deck [0:2][0:9],
  input  wire logic [3:0]           deck_count [0:2],
  input  wire logic                 deck_load [0:2],
  output var card_load_pkg::reader_in_t reader_in
);
  int requested = 0;
  int served    = 0;

  // feed pulses are counted apart so none is lost during a cycle
  always @(posedge clock)
    if (reset_n === 1'b1 && reader_feed === 1'b1)
      requested <= requested + 1;

  task automatic send_field(input logic [3:0] idx, input card_load_pkg::word_t w,
                            input logic lp);
    reader_in.index      <= idx;
    reader_in.word       <= w;
    reader_in.load_punch <= lp;
    @(posedge clock);
    reader_in.strobe <= 1'b1;
    repeat (4) @(posedge clock);
    reader_in.strobe <= 1'b0;
    @(posedge clock);
    reader_in.index      <= ~idx;
    reader_in.word       <= ~w;
    reader_in.load_punch <= ~lp;
    repeat (3) @(posedge clock);
  endtask

  // ----------------------------------------
  // reader cycles: first card read on the third run-in cycle
  // ----------------------------------------
  initial
  begin
    int c;
    reader_in = '0;
    forever
    begin
      @(posedge clock);
      if (served < requested)
      begin
        served = served + 1;
        c = served - RUNIN;
        repeat (FEED_GAP) @(posedge clock);
        if (c >= 0 && c < 3)
          for (int k = 0; k < int'(deck_count[c]); k++)
            send_field(4'(k), deck[c][k], deck_load[c]);
        reader_in.back_cam <= 1'b1;
        repeat (2) @(posedge clock);
        reader_in.back_cam <= 1'b0;
      end
    end
  end
endmodule

`default_nettype wire

// *** testbench/testbench.sv ***
// testbench for the card load control sequencer with a card reader model
`timescale 1ns/1ps
`default_nettype none

module testbench;
  localparam card_load_pkg::word_t ENTRY = 40'h70_0001_0058;
  localparam card_load_pkg::word_t NEXT  = 40'h00_0000_0070;

  logic                       clock = 1'b0;
  logic                       reset_n;
  logic [2:0]                 keys;
  logic                       run_sw;
  card_load_pkg::word_t       entry_sw;
  card_load_pkg::panel_in_t   panel_in;
  card_load_pkg::reader_in_t  reader_in;
  card_load_pkg::word_t       drum_word;
  logic                       drum_word_valid;
  logic [8:0]                 store_address;
  logic                       reader_feed;
  logic                       fetch_request;
  card_load_pkg::addr_t       fetch_address;
  card_load_pkg::word_t       program_register;
  logic [7:0]                 op_register;
  card_load_pkg::addr_t       address_register;
  card_load_pkg::word_t       distributor;
  logic [79:0]                accumulator;
  logic                       fetch_half;
  logic                       back_relay;
  logic                       runin_done;
  card_load_pkg::word_t       store_data;
  card_load_pkg::word_t       deck [0:2][0:9];
  logic [3:0]                 deck_count [0:2];
  logic                       deck_load [0:2];
  int                         miscompares = 0;
  int                         n_compared = 0;
  int                         n_feeds = 0;

  always #50 clock = ~clock;

  assign panel_in = '{program_start: keys[0], read_start: keys[1], computer_reset: keys[2],
                      run_switch: run_sw, entry: entry_sw};

  always @(posedge clock)
    if (reader_feed === 1'b1)
      n_feeds <= n_feeds + 1;

  card_load_control_sequencer i_card_load_control_sequencer (
    .clock(clock), .reset_n(reset_n), .reader_in(reader_in), .panel_in(panel_in),
    .drum_word(drum_word), .drum_word_valid(drum_word_valid), .store_address(store_address),
    .reader_feed(reader_feed), .fetch_request(fetch_request), .fetch_address(fetch_address),
    .program_register(program_register), .op_register(op_register),
    .address_register(address_register), .distributor(distributor),
    .accumulator(accumulator), .fetch_half(fetch_half), .back_relay(back_relay),
    .runin_done(runin_done), .store_data(store_data));

  card_reader_model i_card_reader_model (
    .clock(clock), .reset_n(reset_n), .reader_feed(reader_feed), .deck(deck),
    .deck_count(deck_count), .deck_load(deck_load), .reader_in(reader_in));

  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic finish_test;
    if (miscompares == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic cmp_word(input string what, input card_load_pkg::word_t e,
                          input card_load_pkg::word_t g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cmp_addr(input string what, input card_load_pkg::addr_t e,
                          input card_load_pkg::addr_t g);
    cmp_word(what, {24'h000000, e}, {24'h000000, g});
  endtask

  task automatic cmp_bit(input string what, input logic e, input logic g);
    cmp_word(what, {39'h0, e}, {39'h0, g});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic press(input int k);
    @(posedge clock);
    keys[k] <= 1'b1;
    repeat (4) @(posedge clock);
    keys[k] <= 1'b0;
  endtask

  task automatic wait_hi(input int sel, input int limit);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < limit && !hit; i++)
    begin
      tick(1);
      case (sel)
        0:       hit = (reader_feed === 1'b1);
        1:       hit = (fetch_request === 1'b1);
        default: hit = (runin_done === 1'b1);
      endcase
    end
    if (!hit)
    begin
      miscompares++;
      $display("[ERR] handshake %0d expected 1 seen 0", sel);
      finish_test();
    end
  endtask

  // ----------------------------------------
  // sequence
  // ----------------------------------------
  initial
  begin
    reset_n = 1'b0;
    keys = 3'h0;
    run_sw = 1'b0;
    entry_sw = '0;
    drum_word = '0;
    drum_word_valid = 1'b0;
    store_address = 9'h000;
    for (int c = 0; c < 3; c++)
      for (int k = 0; k < 10; k++)
        deck[c][k] = 40'h00_0000_0000;
    deck[0][0] = 40'h70_0051_0070;
    deck[0][1] = 40'h69_0004_0003;
    deck[0][2] = 40'h24_0000_8000;
    deck[1][0] = 40'h11_1111_1111;
    deck[1][1] = 40'h22_2222_2222;
    deck_count = '{4'h3, 4'h2, 4'h0};
    deck_load = '{1'b1, 1'b0, 1'b0};
    repeat (6) @(posedge clock);
    reset_n <= 1'b1;
    tick(2);
    cmp_word("program_register", '0, program_register);
    cmp_addr("address_register", 16'h0000, address_register);
    cmp_bit("fetch_half", 1'b1, fetch_half);
    cmp_bit("runin_done", 1'b0, runin_done);
    press(1);
    wait_hi(2, 1000);
    cmp_addr("feeds", 16'h0003, 16'(n_feeds));
    cmp_bit("back_relay", 1'b1, back_relay);
    press(1);
    tick(100);
    cmp_addr("feeds", 16'h0003, 16'(n_feeds));
    @(posedge clock);
    entry_sw <= ENTRY;
    run_sw <= 1'b1;
    press(2);
    tick(5);
    cmp_word("program_register", '0, program_register);
    cmp_word("distributor", '0, distributor);
    cmp_word("accumulator", '0, accumulator[39:0]);
    cmp_word("accumulator_upper", '0, accumulator[79:40]);
    cmp_addr("address_register", 16'h8000, address_register);
    cmp_bit("fetch_half", 1'b1, fetch_half);
    press(0);
    wait_hi(0, 100);
    cmp_word("program_register", ENTRY, program_register);
    cmp_addr("op_register", 16'h0070, {8'h00, op_register});
    cmp_addr("address_register", 16'h0001, address_register);
    wait_hi(0, 400);
    cmp_word("program_register", deck[0][0], program_register);
    cmp_addr("address_register", 16'h0051, address_register);
    cmp_bit("back_relay", 1'b0, back_relay);
    wait_hi(1, 400);
    cmp_addr("fetch_address", 16'h0070, fetch_address);
    cmp_addr("op_register", 16'h0000, {8'h00, op_register});
    @(posedge clock);
    drum_word <= NEXT;
    drum_word_valid <= 1'b1;
    @(posedge clock);
    drum_word <= ~NEXT;
    drum_word_valid <= 1'b0;
    tick(1);
    cmp_word("program_register", NEXT, program_register);
    wait_hi(1, 10);
    cmp_addr("address_register", 16'h0070, address_register);
    for (int b = 0; b < 2; b++)
      for (int k = 0; k < 10; k++)
      begin
        @(posedge clock);
        store_address <= 9'(b * 10 + k);
        tick(2);
        cmp_word("store_data", (k < int'(deck_count[b])) ? deck[b][k] : card_load_pkg::BLANK_WORD,
                 store_data);
      end
    press(2);
    tick(5);
    cmp_word("program_register", '0, program_register);
    cmp_addr("address_register", 16'h8000, address_register);
    cmp_bit("fetch_request", 1'b0, fetch_request);
    finish_test();
  end
endmodule

`default_nettype wire
